// File: wdtps_pkg.sv
package wdtps_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned BASE_PERIOD_US = 18_000;
    localparam int unsigned BASE_CYCLES = BASE_PERIOD_US * (CLK_HZ / 1_000_000);
    // register index; byte address is four times the index
    localparam logic [9:0] IDX_TIMER_SETUP = 10'h081;
    localparam logic [11:0] ADDR_TIMER_SETUP = {IDX_TIMER_SETUP, 2'b00};
    localparam logic [11:0] ADDR_STATUS = 12'h0_100;
    localparam logic [11:0] ADDR_CONTROL = 12'h0_104;
    localparam logic [7:0] TIMER_SETUP_RESET = 8'hff;
    localparam int unsigned TARGET_SEL_BIT = 3;
    localparam int unsigned PS_LSB = 0;
    localparam int unsigned PS_W = 3;
    localparam int unsigned CTRL_KICK_BIT = 0;
    localparam int unsigned CTRL_SLEEP_BIT = 1;
    localparam int unsigned CTRL_WAKE_BIT = 2;
    localparam int unsigned ST_EXPIRED_N_BIT = 0;
    localparam int unsigned ST_SLEEP_BIT = 1;
    localparam int unsigned ST_FUSE_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : wdtps_pkg

// File: wdtps_tick.sv
`timescale 1ns/1ps
// base-period tick source standing in for the separate watchdog oscillator
module wdtps_tick #(
    parameter int unsigned PERIOD = 360000
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clr,
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } wdtps_tick_st_t;
    wdtps_tick_st_t s_r, s_nxt;
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (clr) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt >= PERIOD - 1) begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign tick = s_r.tick;
endmodule : wdtps_tick

// File: wdtps_top.sv
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module wdtps_top
    import wdtps_pkg::*;
#(
    parameter int unsigned BASE_PERIOD = wdtps_pkg::BASE_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic watchdog_fuse_on,
    input wire logic kick_instruction,
    input wire logic sleep_instruction,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic device_reset,
    output logic wake,
    output logic sleeping,
    output logic watchdog_expired_n
);
    import wdtps_pkg::*;
    typedef struct packed {
        logic [1:0] fuse_sync;
        logic [1:0] kick_sync;
        logic [1:0] sleep_sync;
        logic [7:0] timer_setup;
        logic [6:0] pre;
        logic aw_got;
        logic w_got;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic wstrb_lo;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic sleeping;
        logic expired_n;
        logic dev_reset;
        logic wake;
    } wdtps_st_t;
    wdtps_st_t s_r, s_nxt;
    logic base_tick;
    logic kick_any;
    logic sleep_any;
    logic wr_go;
    logic [7:0] ratio_max;
    logic expire;
    always_comb begin
        s_nxt = s_r;
        s_nxt.fuse_sync = {s_r.fuse_sync[0], watchdog_fuse_on};
        s_nxt.kick_sync = {s_r.kick_sync[0], kick_instruction};
        s_nxt.sleep_sync = {s_r.sleep_sync[0], sleep_instruction};
        s_nxt.dev_reset = 1'b0;
        s_nxt.wake = 1'b0;
        kick_any = s_r.kick_sync[1];
        sleep_any = s_r.sleep_sync[1];
        wr_go = s_r.aw_got && s_r.w_got && !s_r.bvalid;
        if (wr_go && s_r.awaddr == ADDR_CONTROL && s_r.wdata[CTRL_KICK_BIT]) begin
            kick_any = 1'b1;
        end
        if (wr_go && s_r.awaddr == ADDR_CONTROL && s_r.wdata[CTRL_SLEEP_BIT]) begin
            sleep_any = 1'b1;
        end
        // ratio 1:1 when unassigned or bits zero
        ratio_max = 8'h00;
        if (s_r.timer_setup[TARGET_SEL_BIT]) begin
            ratio_max = 8'((16'h0001 << s_r.timer_setup[PS_LSB +: PS_W]) - 16'h0001);
        end
        expire = 1'b0;
        if (kick_any || sleep_any) begin
            s_nxt.pre = '0;
        end else if (base_tick && s_r.fuse_sync[1]) begin
            if ({1'b0, s_r.pre} >= ratio_max) begin
                s_nxt.pre = '0;
                expire = 1'b1;
            end else begin
                s_nxt.pre = s_r.pre + 7'h01;
            end
        end
        if (sleep_any) begin
            s_nxt.sleeping = 1'b1;
        end
        if (wr_go && s_r.awaddr == ADDR_CONTROL && s_r.wdata[CTRL_WAKE_BIT]) begin
            s_nxt.sleeping = 1'b0;
        end
        // a same-cycle kick blocks expiry, so the flag restore wins
        if (kick_any) begin
            s_nxt.expired_n = 1'b1;
        end
        if (expire) begin
            s_nxt.expired_n = 1'b0;
            if (s_r.sleeping) begin
                s_nxt.wake = 1'b1;
                s_nxt.sleeping = 1'b0;
            end else begin
                s_nxt.dev_reset = 1'b1;
            end
        end
        if (s_axi_awvalid && !s_r.aw_got) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_got) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb_lo = s_axi_wstrb[0];
        end
        if (wr_go) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bresp = RESP_OKAY;
            if (s_r.awaddr == ADDR_TIMER_SETUP) begin
                // only byte lane 0 carries the register
                if (s_r.wstrb_lo) begin
                    s_nxt.timer_setup = s_r.wdata[7:0];
                end
            end else if (s_r.awaddr != ADDR_CONTROL) begin
                s_nxt.bresp = RESP_SLVERR;
            end
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            s_nxt.rdata = '0;
            case (s_axi_araddr)
                ADDR_TIMER_SETUP: s_nxt.rdata[7:0] = s_r.timer_setup;
                ADDR_STATUS: begin
                    s_nxt.rdata[ST_EXPIRED_N_BIT] = s_r.expired_n;
                    s_nxt.rdata[ST_SLEEP_BIT] = s_r.sleeping;
                    s_nxt.rdata[ST_FUSE_BIT] = s_r.fuse_sync[1];
                end
                ADDR_CONTROL: s_nxt.rdata = '0;
                default: s_nxt.rresp = RESP_SLVERR;
            endcase
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.timer_setup <= TIMER_SETUP_RESET;
            s_r.expired_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
    // kicks also restart the base divider so a full period follows
    wdtps_tick #(
        .PERIOD(BASE_PERIOD)
    ) u_tick (
        .clk(clk),
        .nrst(nrst),
        .clr(kick_any || sleep_any),
        .tick(base_tick)
    );
    assign s_axi_awready = !s_r.aw_got;
    assign s_axi_wready = !s_r.w_got;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign device_reset = s_r.dev_reset;
    assign wake = s_r.wake;
    assign sleeping = s_r.sleeping;
    assign watchdog_expired_n = s_r.expired_n;

    property p_reset_awake;
        @(posedge clk) disable iff (!nrst)
        (expire && !s_r.sleeping) |=> (device_reset && !wake);
    endproperty
    a_reset_awake: assert property (p_reset_awake) else $error("no reset on expiry");
    property p_wake_sleep;
        @(posedge clk) disable iff (!nrst)
        (expire && s_r.sleeping) |=> (wake && !device_reset && !sleeping);
    endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("no wake on expiry");
    property p_fuse_off;
        @(posedge clk) disable iff (!nrst)
        !s_r.fuse_sync[1] |-> !expire;
    endproperty
    a_fuse_off: assert property (p_fuse_off) else $error("expiry with fuse off");
    property p_flag_clear;
        @(posedge clk) disable iff (!nrst)
        expire |=> !watchdog_expired_n;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
    property p_kick_clears;
        @(posedge clk) disable iff (!nrst)
        (kick_any || sleep_any) |=> (s_r.pre == 7'h00 && !expire);
    endproperty
    a_kick_clears: assert property (p_kick_clears) else $error("kick did not clear");
    property p_unassigned;
        @(posedge clk) disable iff (!nrst)
        (!s_r.timer_setup[TARGET_SEL_BIT] && base_tick && s_r.fuse_sync[1] && !kick_any && !sleep_any)
            |-> expire;
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("base tick missed");
    property p_ratio;
        @(posedge clk) disable iff (!nrst)
        expire |-> ({1'b0, s_r.pre} == ratio_max);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio mismatch");
    property p_pre_bound;
        @(posedge clk) disable iff (!nrst)
        s_r.timer_setup[TARGET_SEL_BIT] |-> ({1'b0, s_r.pre} <= ratio_max || $changed(s_r.timer_setup));
    endproperty
    a_pre_bound: assert property (p_pre_bound) else $error("prescaler overrun");
endmodule : wdtps_top

// File: wdtps_core_model.sv
`timescale 1ns/1ps
// processor core side: issues kick and sleep instructions
module wdtps_core_model (
    input wire logic clk,
    output logic kick_instruction,
    output logic sleep_instruction
);
    initial begin
        kick_instruction = 1'b0;
        sleep_instruction = 1'b0;
    end
    // n > 1 models a slow core holding the instruction longer
    task automatic issue(input logic sleep, input int n);
        @(posedge clk);
        kick_instruction <= !sleep;
        sleep_instruction <= sleep;
        repeat (n) @(posedge clk);
        kick_instruction <= 1'b0;
        sleep_instruction <= 1'b0;
    endtask : issue
endmodule : wdtps_core_model

// File: wdtps_tb_top.sv
`timescale 1ns/1ps
module wdtps_tb_top;
    import wdtps_pkg::*;
    localparam int unsigned BP = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic fuse = 1'b1;
    logic kick, slp, awrdy, wrdy, bvalid, arrdy, rvalid, dev_rst, wake, sleeping, exp_n;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp;
    int errors = 0;
    int cmp_count = 0;
    int ev_cnt = 0;
    always #25 clk = ~clk;
    // negedge so counts never race the tasks sampling at posedge
    always @(negedge clk) begin
        if (dev_rst === 1'b1 || wake === 1'b1) ev_cnt++;
    end
    wdtps_core_model u_core (.clk(clk), .kick_instruction(kick), .sleep_instruction(slp));
    wdtps_top #(.BASE_PERIOD(BP)) u_dut (.clk(clk), .nrst(nrst), .watchdog_fuse_on(fuse),
        .kick_instruction(kick), .sleep_instruction(slp), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .device_reset(dev_rst), .wake(wake), .sleeping(sleeping), .watchdog_expired_n(exp_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        cmp_count++;
        if (got < lo || got > hi) begin
            errors++;
            $display("[ERR] %0t %s took %0d cycles", $time, what, got);
        end
    endtask : chk_rng
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awrdy) awvalid <= 1'b0;
            if (wvalid && wrdy) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        chk_rng(n, 1, 99, "write wait");
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arrdy) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        chk_rng(n, 1, 99, "read wait");
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    // kick or sleep, then cycles until the first expiry pulse
    task automatic time_expiry(input logic sl, output int n, output logic w);
        u_core.issue(sl, 1);
        n = 0;
        while (dev_rst !== 1'b1 && wake !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        w = wake;
    endtask : time_expiry
    task automatic s_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(ADDR_TIMER_SETUP, d, r);
        chk(d, 32'h0000_00ff, "setup reset");
        axi_rd(ADDR_STATUS, d, r);
        chk(d, 32'h0000_0005, "status reset");
        axi_wr(ADDR_TIMER_SETUP, 32'h0000_005a, r);
        axi_rd(ADDR_TIMER_SETUP, d, r);
        chk(d, 32'h0000_005a, "setup readback");
        axi_rd(12'h300, d, r);
        chk(d, 32'h0000_0000, "unmapped data");
        chk(32'(r), 32'(RESP_SLVERR), "unmapped read");
        axi_wr(12'h300, 32'h0000_0001, r);
        chk(32'(r), 32'(RESP_SLVERR), "unmapped write");
    endtask : s_regs
    task automatic s_expiry();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        logic w;
        // ratio bits set but ignored while the prescaler is not assigned
        axi_wr(ADDR_TIMER_SETUP, 32'h0000_0007, r);
        time_expiry(1'b0, n, w);
        chk_rng(n, BP - 1, BP + 8, "base period");
        for (int k = 0; k < 8; k++) begin
            axi_wr(ADDR_TIMER_SETUP, 32'h0000_0008 | k, r);
            time_expiry(1'b0, n, w);
            chk_rng(n, (BP << k) - 1, (BP << k) + 8, "scaled period");
            chk(32'(w), 32'h0000_0000, "woke while awake");
            @(posedge clk);
            chk(32'(exp_n), 32'h0000_0000, "flag after expiry");
        end
        axi_rd(ADDR_STATUS, d, r);
        chk(d, 32'h0000_0004, "status after expiry");
    endtask : s_expiry
    task automatic s_keep();
        logic [1:0] r;
        int c;
        u_core.issue(1'b0, 1);
        axi_wr(ADDR_TIMER_SETUP, 32'h0000_0000, r);
        u_core.issue(1'b0, 1);
        c = ev_cnt;
        repeat (6) begin
            repeat (10) @(posedge clk);
            u_core.issue(1'b0, 2);
        end
        repeat (3) begin
            repeat (10) @(posedge clk);
            axi_wr(ADDR_CONTROL, 32'h0000_0001, r);
        end
        chk(32'(ev_cnt - c), 32'h0000_0000, "reset despite kicks");
        chk(32'(exp_n), 32'h0000_0001, "flag after kick");
    endtask : s_keep
    task automatic s_sleep();
        logic [1:0] r;
        int n;
        logic w;
        time_expiry(1'b1, n, w);
        chk(32'(w), 32'h0000_0001, "wake from sleep");
        chk(32'(dev_rst), 32'h0000_0000, "reset in sleep");
        chk_rng(n, BP - 1, BP + 8, "sleep period");
        axi_wr(ADDR_CONTROL, 32'h0000_0002, r);
        chk(32'(sleeping), 32'h0000_0001, "sleep by register");
        axi_wr(ADDR_CONTROL, 32'h0000_0004, r);
        chk(32'(sleeping), 32'h0000_0000, "left sleep");
    endtask : s_sleep
    task automatic s_fuse();
        logic [31:0] d;
        logic [1:0] r;
        int c;
        @(posedge clk);
        fuse <= 1'b0;
        repeat (5) @(posedge clk);
        c = ev_cnt;
        repeat (10 * BP) @(posedge clk);
        chk(32'(ev_cnt - c), 32'h0000_0000, "expiry with fuse off");
        axi_rd(ADDR_STATUS, d, r);
        chk(d & 32'h0000_0004, 32'h0000_0000, "fuse status");
        fuse <= 1'b1;
    endtask : s_fuse
    task automatic report_and_stop();
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        s_regs();
        s_expiry();
        s_keep();
        s_sleep();
        s_fuse();
        report_and_stop();
    end
    // about three and a half times the expected run length
    initial begin
        #(20000 * 50);
        errors++;
        $display("[ERR] %0t watchdog timeout", $time);
        report_and_stop();
    end
endmodule : wdtps_tb_top
